/* File: src/ccp_pkg.sv */
// Package: register map, field positions, reset values and codes for clock source control
`default_nettype none
package ccp_pkg;
   // Register byte offsets
   localparam logic [7:0] CCP_OFS_SRC_A = 8'h09; // Source selects, dividers 0 and 1
   localparam logic [7:0] CCP_OFS_CTRL = 8'h0A; // Pin modes, input select, divider 2 source
   localparam logic [7:0] CCP_OFS_INSRC = 8'h0B; // Input type, dividers 3 and 4
   localparam logic [7:0] CCP_OFS_SRC_B = 8'h0C; // Power-down, divider 5 source
   // Control byte fields
   localparam int CCP_PIN0_MODE_LSB = 0; // pin_zero_mode_hi/lo at [1:0]
   localparam int CCP_PIN1_MODE_LSB = 2; // pin_one_mode_hi/lo at [3:2]
   localparam int CCP_INSEL_BIT = 4; // input_select_bit
   localparam int CCP_SRC2_LSB = 5; // Divider 2 source at [7:5]
   // Input source byte fields
   localparam int CCP_SRC3_LSB = 0; // Divider 3 source at [2:0]
   localparam int CCP_SRC4_LSB = 3; // Divider 4 source at [5:3]
   localparam int CCP_ITYPE_LSB = 6; // source_type_hi/lo at [7:6]
   // Source select byte fields
   localparam int CCP_SRC0_LSB = 0; // Divider 0 source, byte A [2:0]
   localparam int CCP_SRC1_LSB = 3; // Divider 1 source, byte A [5:3]
   localparam int CCP_SRC5_LSB = 0; // Divider 5 source, byte B [2:0]
   localparam int CCP_PD_BIT = 6; // register_powerdown, byte B [6]
   // Reset values: P0 on unmodulated PLL2, P1 on PLL3, the rest on PLL1
   localparam logic [7:0] CCP_RST_SRC_A = 8'h22;
   localparam logic [7:0] CCP_RST_CTRL = 8'h20;
   localparam logic [7:0] CCP_RST_INSRC = 8'h09;
   localparam logic [7:0] CCP_RST_SRC_B = 8'h01;
   // Post-divider source codes
   localparam logic [2:0] CCP_SRC_BYPASS = 3'h0;
   localparam logic [2:0] CCP_SRC_PLL1 = 3'h1;
   localparam logic [2:0] CCP_SRC_PLL2 = 3'h2;
   localparam logic [2:0] CCP_SRC_PLL2_SPREAD = 3'h3;
   localparam logic [2:0] CCP_SRC_PLL3 = 3'h4;
   // Control pin modes
   localparam logic [1:0] CCP_P0_POWERDOWN = 2'h0;
   localparam logic [1:0] CCP_P0_BYPASS = 2'h1;
   localparam logic [1:0] CCP_P0_INPUT_SELECT_BIT = 2'h2;
   localparam logic [1:0] CCP_P_ADDRESS = 2'h3;
   localparam logic [1:0] CCP_P1_FORCE_LOW = 2'h0;
   localparam logic [1:0] CCP_P1_TRISTATE = 2'h1;
   // Input source types
   localparam logic [1:0] CCP_IN_CRYSTAL = 2'h0;
   localparam logic [1:0] CCP_IN_SINGLE = 2'h1;
   localparam logic [1:0] CCP_IN_DIFF = 2'h2;
   // Dimensions
   localparam int CCP_NUM_DIV = 6; // Post-dividers fed by the switch
   localparam int CCP_SRC_W = 3; // Source code width
endpackage
`default_nettype wire

/* File: src/ccp_src_mux.sv */
// One post-divider source selector with registered output
`default_nettype none
module ccp_src_mux
   import ccp_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic [2:0] sel,
   input wire logic bypass_all,
   input wire logic ref_clk,
   input wire logic pll1_clk,
   input wire logic pll2_clk,
   input wire logic pll2_spread_clk,
   input wire logic pll3_clk,
   output logic src_out_r
);
   logic src_out_nxt; // Selected level

   // Decode the code; reserved codes give a quiet low
   always_comb begin
      src_out_nxt = 1'b0;
      if (bypass_all) begin
         src_out_nxt = ref_clk; // Whole synthesis chain skipped
      end else begin
         unique case (sel)
            CCP_SRC_BYPASS: src_out_nxt = ref_clk;
            CCP_SRC_PLL1: src_out_nxt = pll1_clk;
            CCP_SRC_PLL2: src_out_nxt = pll2_clk;
            CCP_SRC_PLL2_SPREAD: src_out_nxt = pll2_spread_clk;
            CCP_SRC_PLL3: src_out_nxt = pll3_clk;
            default: src_out_nxt = 1'b0; // Reserved
         endcase
      end
   end

   // Output register
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         src_out_r <= 1'b0;
      end else begin
         src_out_r <= src_out_nxt;
      end
   end
endmodule
`default_nettype wire

/* File: src/ccp_clock_ctrl.sv */
// Clock source switch, control pin decode, input select and address bits
`default_nettype none
module ccp_clock_ctrl
   import ccp_pkg::*;
#(
   parameter logic [6:0] BASE_ADDR = 7'h68 // Slave address base, arbitrary value
)
(
   input wire logic clk_sys,
   input wire logic rst_b,
   // Byte port from the serial management engine
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata_r,
   // Slave address check request from the serial engine
   input wire logic addr_chk_en,
   input wire logic [6:0] addr_chk_value,
   output logic addr_match_r,
   output logic slave_addr_bit_zero_r,
   output logic slave_addr_bit_one_r,
   // Board control pins
   input wire logic first_control_pin,
   input wire logic second_control_pin,
   // Spread bypass request from the modulation settings
   input wire logic spread_bypass,
   // Clock sources
   input wire logic clock_input_zero,
   input wire logic clock_input_one,
   // PLL outputs
   input wire logic pll1_clk,
   input wire logic pll2_clk,
   input wire logic pll2_spread_raw,
   input wire logic pll3_clk,
   // Controls to the analog core
   // Power controls
   output logic pll_powerdown_r,
   output logic input_stage_pd_r,
   output logic spread_modulation_pd_r,
   output logic divider_bypass_r,
   // Output stage controls; polarity is applied further on
   output logic outputs_tristate_r,
   output logic outputs_force_inactive_r,
   // Input stage controls
   output logic crystal_en_r,
   output logic diff_en_r,
   output logic input_one_sel_r,
   // Switch outputs, one level per post-divider
   output logic [CCP_NUM_DIV-1:0] post_divider_n_src_r
);
   // Configuration bytes, kept through every power-down
   logic [7:0] src_a_r; // Divider 0 and 1 source codes
   logic [7:0] src_a_nxt; // Its next value
   logic [7:0] ctrl_r; // Pin modes, input select, divider 2 source
   logic [7:0] ctrl_nxt; // Its next value
   logic [7:0] insrc_r; // Input type, divider 3 and 4 source codes
   logic [7:0] insrc_nxt; // Its next value
   logic [7:0] src_b_r; // Power-down bit, divider 5 source code
   logic [7:0] src_b_nxt; // Its next value
   logic [7:0] rdata_nxt; // Byte shown after a read strobe

   // Decoded control levels
   // Mode and type fields
   logic [1:0] pin0_mode; // First pin function
   logic [1:0] pin1_mode; // Second pin function
   logic [1:0] in_type; // Input source type
   // Power and output requests
   logic reg_pd; // Register power-down bit
   logic pin0_pd; // First pin asks for power-down
   logic pin0_bypass; // First pin asks for divider bypass
   logic pin1_low; // Second pin asks for inactive level
   logic pin1_tri; // Second pin asks for release
   logic pd_all; // Power-down from either source
   // Input path
   logic sel_one; // Input one chosen
   logic ref_clk; // Reference level after the input mux
   logic spread_clk; // Modulated PLL2 level after gating
   // Effective slave address bits
   logic a0; // Bit zero, pin or base
   logic a1; // Bit one, pin or base

   // Registered control outputs, next values
   logic pll_pd_nxt; // All PLLs off
   logic in_pd_nxt; // Input stage off
   logic ssc_pd_nxt; // Modulator off
   logic byp_nxt; // Dividers skipped, also steers the selectors
   logic tri_nxt; // Outputs released
   logic frc_nxt; // Outputs at inactive level
   logic xtal_nxt; // Crystal oscillator enabled
   logic diff_nxt; // Differential receiver enabled
   logic sel_nxt; // Input one routed
   logic match_nxt; // Result of the pending address check

   // Source codes for the six selectors
   logic [CCP_SRC_W-1:0] src_sel [CCP_NUM_DIV];

   // Byte read decode, used by read path
   // Unmapped offsets read as zero; other blocks own the rest of the map,
   // so no error flag is raised here
   function automatic logic [7:0] rd_byte(input logic [7:0] a, input logic [7:0] b0,
         input logic [7:0] b1, input logic [7:0] b2, input logic [7:0] b3);
      logic [7:0] v;
      v = 8'h00;
      unique case (a)
         CCP_OFS_SRC_A: v = b0;
         CCP_OFS_CTRL: v = b1;
         CCP_OFS_INSRC: v = b2;
         CCP_OFS_SRC_B: v = b3;
         default: v = 8'h00; // Outside this block's map
      endcase
      return v;
   endfunction

   // Register write and read; every byte is full read/write
   // A read in the cycle of a write still returns the old byte
   // Single-byte port: the serial engine splits block writes into bytes
   always_comb begin
      src_a_nxt = src_a_r;
      ctrl_nxt = ctrl_r;
      insrc_nxt = insrc_r;
      src_b_nxt = src_b_r;
      rdata_nxt = reg_rdata_r;
      // Writes outside the four offsets fall through
      if (reg_wr_en) begin
         unique case (reg_addr)
            CCP_OFS_SRC_A: src_a_nxt = reg_wdata;
            CCP_OFS_CTRL: ctrl_nxt = reg_wdata;
            CCP_OFS_INSRC: insrc_nxt = reg_wdata;
            CCP_OFS_SRC_B: src_b_nxt = reg_wdata;
            default: ; // Other bytes belong elsewhere
         endcase
      end
      // Read samples the stored bytes, not this cycle's write
      if (reg_rd_en) begin
         rdata_nxt = rd_byte(reg_addr, src_a_r, ctrl_r, insrc_r, src_b_r);
      end
   end

   // Register storage; power-down never clears it
   // Only the asynchronous reset loads the defaults
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         src_a_r <= CCP_RST_SRC_A;
         ctrl_r <= CCP_RST_CTRL;
         insrc_r <= CCP_RST_INSRC;
         src_b_r <= CCP_RST_SRC_B;
         reg_rdata_r <= 8'h00;
      end else begin
         // Bytes change only through the write path
         src_a_r <= src_a_nxt;
         ctrl_r <= ctrl_nxt;
         insrc_r <= insrc_nxt;
         src_b_r <= src_b_nxt;
         reg_rdata_r <= rdata_nxt;
      end
   end

   // Field extraction
   // Every position comes from the package, so the map lives in one place
   assign pin0_mode = ctrl_r[CCP_PIN0_MODE_LSB +: 2];
   assign pin1_mode = ctrl_r[CCP_PIN1_MODE_LSB +: 2];
   assign in_type = insrc_r[CCP_ITYPE_LSB +: 2];
   assign reg_pd = src_b_r[CCP_PD_BIT];
   // Source codes, two or one per byte
   assign src_sel[0] = src_a_r[CCP_SRC0_LSB +: CCP_SRC_W];
   assign src_sel[1] = src_a_r[CCP_SRC1_LSB +: CCP_SRC_W];
   assign src_sel[2] = ctrl_r[CCP_SRC2_LSB +: CCP_SRC_W];
   assign src_sel[3] = insrc_r[CCP_SRC3_LSB +: CCP_SRC_W];
   assign src_sel[4] = insrc_r[CCP_SRC4_LSB +: CCP_SRC_W];
   assign src_sel[5] = src_b_r[CCP_SRC5_LSB +: CCP_SRC_W];

   // Pin mode decode; reserved pin1 code 10 does nothing
   // Pins are taken as synchronous; a board that drives them from
   // another clock must settle them first, or a request may glitch
   assign pin0_pd = (pin0_mode == CCP_P0_POWERDOWN) && !first_control_pin;
   assign pin0_bypass = (pin0_mode == CCP_P0_BYPASS) && !first_control_pin;
   assign pin1_low = (pin1_mode == CCP_P1_FORCE_LOW) && !second_control_pin;
   assign pin1_tri = (pin1_mode == CCP_P1_TRISTATE) && !second_control_pin;
   // Register power-down joins the pin request here
   assign pd_all = reg_pd || pin0_pd;

   // Address bits follow pins in address mode, else the base
   // Decoded from the stored byte, so a write is live on the next check
   // Limitation: a pin moving between the check strobe and the address
   // byte is left to the serial engine, not caught here
   assign a0 = (pin0_mode == CCP_P_ADDRESS) ? first_control_pin : BASE_ADDR[0];
   assign a1 = (pin1_mode == CCP_P_ADDRESS) ? second_control_pin : BASE_ADDR[1];

   // Input selection: pin mode overrides the bit, single-ended only
   // Reserved type 11 also falls back to input zero
   always_comb begin
      sel_one = 1'b0;
      // Default input zero covers every non-single-ended type
      if (in_type == CCP_IN_SINGLE) begin
         if (pin0_mode == CCP_P0_INPUT_SELECT_BIT) begin
            sel_one = first_control_pin;
         end else begin
            sel_one = ctrl_r[CCP_INSEL_BIT];
         end
      end
      // Crystal and differential always start at input zero
   end

   // Reference level; input stage gives nothing while powered down
   // Holding it low keeps a bypassed divider from seeing a dying clock
   assign ref_clk = pd_all ? 1'b0 : (sel_one ? clock_input_one : clock_input_zero);
   // Modulated PLL2 held low while spread bypass is requested
   assign spread_clk = spread_bypass ? 1'b0 : pll2_spread_raw;

   // Control output next values
   // Power-down outranks both pin output modes and the bypass request
   always_comb begin
      // Power controls
      pll_pd_nxt = pd_all || pin0_bypass;
      in_pd_nxt = pd_all;
      ssc_pd_nxt = spread_bypass || pd_all || pin0_bypass;
      byp_nxt = pin0_bypass && !reg_pd;
      // Output stage
      tri_nxt = pd_all || pin1_tri;
      frc_nxt = pin1_low && !pd_all; // Power-down wins
      // Input stage
      xtal_nxt = (in_type == CCP_IN_CRYSTAL);
      diff_nxt = (in_type == CCP_IN_DIFF);
      sel_nxt = sel_one;
      // Address check result holds until the next strobe
      match_nxt = addr_chk_en ? (addr_chk_value == {BASE_ADDR[6:2], a1, a0})
                              : addr_match_r;
   end

   // Control output registers
   // Every output leaves a flop, so the analog core sees no decode glitch
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         // Quiet levels: powered, crystal-fed, nothing forced
         pll_powerdown_r <= 1'b0;
         input_stage_pd_r <= 1'b0;
         spread_modulation_pd_r <= 1'b0;
         divider_bypass_r <= 1'b0;
         outputs_tristate_r <= 1'b0;
         outputs_force_inactive_r <= 1'b0;
         // Crystal is the default input type
         crystal_en_r <= 1'b1;
         diff_en_r <= 1'b0;
         input_one_sel_r <= 1'b0;
         // No address checked yet
         addr_match_r <= 1'b0;
         slave_addr_bit_zero_r <= 1'b0;
         slave_addr_bit_one_r <= 1'b0;
      end else begin
         // Follow the decode one edge late
         pll_powerdown_r <= pll_pd_nxt;
         input_stage_pd_r <= in_pd_nxt;
         spread_modulation_pd_r <= ssc_pd_nxt;
         divider_bypass_r <= byp_nxt;
         outputs_tristate_r <= tri_nxt;
         outputs_force_inactive_r <= frc_nxt;
         crystal_en_r <= xtal_nxt;
         diff_en_r <= diff_nxt;
         input_one_sel_r <= sel_nxt;
         addr_match_r <= match_nxt;
         // Address bits as the serial engine should compare them
         slave_addr_bit_zero_r <= a0;
         slave_addr_bit_one_r <= a1;
      end
   end

   // Six source selectors
   // Bypass comes from the next value, so the switch moves on the same
   // edge as divider_bypass_r rather than one cycle behind it
   for (genvar i = 0; i < CCP_NUM_DIV; i++) begin : g_mux
      // Each selector registers its own output
      ccp_src_mux u_mux (
         .clk_sys(clk_sys),
         .rst_b(rst_b),
         .sel(src_sel[i]),
         .bypass_all(byp_nxt),
         .ref_clk(ref_clk),
         .pll1_clk(pll1_clk),
         .pll2_clk(pll2_clk),
         .pll2_spread_clk(spread_clk),
         .pll3_clk(pll3_clk),
         .src_out_r(post_divider_n_src_r[i])
      );
   end
endmodule
`default_nettype wire

/* File: dv/ccp_clock_ctrl_properties.sv */
// Checker of the clock source and control pin decode, bound to the top module
`default_nettype none
module ccp_clock_ctrl_checker #(
   parameter logic [6:0] BASE_ADDR = 7'h68 // Slave address base, arbitrary value
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic addr_chk_en,
   input wire logic [6:0] addr_chk_value,
   input wire logic addr_match_r,
   input wire logic slave_addr_bit_zero_r,
   input wire logic slave_addr_bit_one_r,
   input wire logic first_control_pin,
   input wire logic second_control_pin,
   input wire logic spread_bypass,
   input wire logic pll_powerdown_r,
   input wire logic input_stage_pd_r,
   input wire logic spread_modulation_pd_r,
   input wire logic divider_bypass_r,
   input wire logic outputs_tristate_r,
   input wire logic outputs_force_inactive_r,
   input wire logic crystal_en_r,
   input wire logic diff_en_r,
   input wire logic input_one_sel_r
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_sys);
   endclocking
   // Reset clears every output but crystal_en_r, so relations are off while it is low
   default disable iff (!rst_b);
   property p_pd; input_stage_pd_r |-> outputs_tristate_r && pll_powerdown_r; endproperty
   a_pd: assert property (p_pd) else $error("power-down without tristate");
   property p_prio; input_stage_pd_r |-> !outputs_force_inactive_r; endproperty
   a_prio: assert property (p_prio) else $error("force level during power-down");
   property p_byp;
      divider_bypass_r |-> pll_powerdown_r && !input_stage_pd_r && !$past(first_control_pin);
   endproperty
   a_byp: assert property (p_byp) else $error("bypass state wrong");
   property p_force; outputs_force_inactive_r |-> !$past(second_control_pin); endproperty
   a_force: assert property (p_force) else $error("force level with pin high");
   property p_spr; $past(spread_bypass) && $past(rst_b) |-> spread_modulation_pd_r; endproperty
   a_spr: assert property (p_spr) else $error("modulator left on");
   property p_type;
      crystal_en_r || diff_en_r |-> !input_one_sel_r && !(crystal_en_r && diff_en_r);
   endproperty
   a_type: assert property (p_type) else $error("input select in wrong type");
   // A moved address bit can only come from the pin one edge before
   property p_a0;
      slave_addr_bit_zero_r != BASE_ADDR[0] && $past(rst_b)
         |-> slave_addr_bit_zero_r == $past(first_control_pin);
   endproperty
   a_a0: assert property (p_a0) else $error("address bit zero wrong");
   property p_a1;
      slave_addr_bit_one_r != BASE_ADDR[1] && $past(rst_b)
         |-> slave_addr_bit_one_r == $past(second_control_pin);
   endproperty
   a_a1: assert property (p_a1) else $error("address bit one wrong");
   property p_match; addr_chk_en && addr_chk_value[6:2] != BASE_ADDR[6:2] |=> !addr_match_r;
   endproperty
   a_match: assert property (p_match) else $error("match on foreign address");
   c_byp: cover property (divider_bypass_r);
   c_force: cover property (outputs_force_inactive_r);
   c_match: cover property ($rose(addr_match_r));
endmodule
bind ccp_clock_ctrl ccp_clock_ctrl_checker #(.BASE_ADDR(BASE_ADDR)) i_chk (
   .clk_sys, .rst_b, .addr_chk_en, .addr_chk_value, .addr_match_r, .slave_addr_bit_zero_r,
   .slave_addr_bit_one_r, .first_control_pin, .second_control_pin, .spread_bypass,
   .pll_powerdown_r, .input_stage_pd_r, .spread_modulation_pd_r, .divider_bypass_r,
   .outputs_tristate_r, .outputs_force_inactive_r, .crystal_en_r, .diff_en_r, .input_one_sel_r
);
`default_nettype wire

/* File: dv/ccp_board_model.sv */
// Board model: clock source levels and control pins, prompt or slow
`default_nettype none
module ccp_board_model (
   input wire logic clk_sys,
   input wire logic slow,
   input wire logic [7:0] req,
   output logic [5:0] src,
   output logic [1:0] pins
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] stage_r; // Extra stage for a slow board
   // Levels follow the request one or two edges later
   always @(posedge clk_sys) begin
      stage_r <= req;
      {pins, src} <= slow ? stage_r : req;
   end
endmodule
`default_nettype wire

/* File: dv/clock_source_and_control_pin_config_tb_top.sv */
// Self-checking bench for the clock source and control pin decode
`default_nettype none
module clock_source_and_control_pin_config_tb_top
   import ccp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [6:0] BASE = 7'h5A; // Arbitrary slave address base
   logic clk_sys = 1'h0, rst_b = 1'h0, reg_wr_en = 1'h0, reg_rd_en = 1'h0, slow = 1'h0;
   logic addr_chk_en = 1'h0, spread_bypass = 1'h0, addr_match_r, a0, a1;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata_r, req = 8'hC0, r[4];
   logic [6:0] addr_chk_value = 7'h00, ea, ca;
   logic [5:0] src, pdn;
   logic [1:0] pins, obs = 2'h0;
   logic [8:0] ctl;
   logic [16:0] e, q_exp[$], q_msk[$];
   logic [31:0] rnd = 32'h0000002F, v, w;
   logic [7:0] rst_val[4] = '{CCP_RST_SRC_A, CCP_RST_CTRL, CCP_RST_INSRC, CCP_RST_SRC_B};
   int err_count = 0, check_count = 0;
   ccp_clock_ctrl #(.BASE_ADDR(BASE)) i_dut (
      .clk_sys, .rst_b, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata_r,
      .addr_chk_en, .addr_chk_value, .addr_match_r, .slave_addr_bit_zero_r(a0),
      .slave_addr_bit_one_r(a1), .first_control_pin(pins[0]), .second_control_pin(pins[1]),
      .spread_bypass, .clock_input_zero(src[5]), .clock_input_one(src[4]), .pll1_clk(src[3]),
      .pll2_clk(src[2]), .pll2_spread_raw(src[1]), .pll3_clk(src[0]), .pll_powerdown_r(ctl[8]),
      .input_stage_pd_r(ctl[7]), .spread_modulation_pd_r(ctl[6]), .divider_bypass_r(ctl[5]),
      .outputs_tristate_r(ctl[4]), .outputs_force_inactive_r(ctl[3]), .crystal_en_r(ctl[2]),
      .diff_en_r(ctl[1]), .input_one_sel_r(ctl[0]), .post_divider_n_src_r(pdn)
   );
   ccp_board_model i_board (.clk_sys, .slow, .req, .src, .pins);
   initial begin
      forever #2.5 clk_sys = ~clk_sys;
   end
   function automatic logic [31:0] xs();
      rnd ^= rnd << 13;
      rnd ^= rnd >> 17;
      rnd ^= rnd << 5;
      return rnd;
   endfunction
   // Expected outputs from register bytes, pins {1,0}, source levels and spread bypass
   function automatic logic [16:0] exp_stat(input logic [7:0] b[4], input logic [1:0] p,
                                            input logic [5:0] s, input logic sb);
      logic [2:0] c[6];
      logic [5:0] o;
      logic pd, byp, sel1, rl;
      pd = b[3][6] | (!p[0] && b[1][1:0] == CCP_P0_POWERDOWN);
      byp = !b[3][6] && !p[0] && b[1][1:0] == CCP_P0_BYPASS;
      sel1 = b[2][7:6] == CCP_IN_SINGLE && (b[1][1:0] == CCP_P0_INPUT_SELECT_BIT ? p[0] : b[1][4]);
      rl = !pd && (sel1 ? s[4] : s[5]); // Input stage off gives a low reference
      c = '{b[0][2:0], b[0][5:3], b[1][7:5], b[2][2:0], b[2][5:3], b[3][2:0]};
      for (int i = 0; i < 6; i++) begin
         o[i] = byp || c[i] == CCP_SRC_BYPASS ? rl : c[i] == CCP_SRC_PLL1 ? s[3] :
                c[i] == CCP_SRC_PLL2 ? s[2] : c[i] == CCP_SRC_PLL2_SPREAD ? s[1] & !sb :
                c[i] == CCP_SRC_PLL3 ? s[0] : 1'h0;
      end
      return {b[1][3:2] == CCP_P_ADDRESS ? p[1] : BASE[1],
              b[1][1:0] == CCP_P_ADDRESS ? p[0] : BASE[0], pd | byp, pd, sb | pd | byp, byp,
              pd | (b[1][3:2] == CCP_P1_TRISTATE && !p[1]),
              !pd && b[1][3:2] == CCP_P1_FORCE_LOW && !p[1], b[2][7:6] == CCP_IN_CRYSTAL,
              b[2][7:6] == CCP_IN_DIFF, sel1, o};
   endfunction
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_wr_en <= 1'h1;
      reg_addr <= a;
      reg_wdata <= d;
   endtask
   // Notes the expectation, drops every strobe and flags the monitor for one cycle
   task automatic observe(input logic [1:0] k, input logic [16:0] x, input logic [16:0] m);
      @(posedge clk_sys);
      {reg_wr_en, reg_rd_en, addr_chk_en} <= 3'h0;
      q_exp.push_back(x);
      q_msk.push_back(m);
      obs <= k;
      @(posedge clk_sys);
      obs <= 2'h0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] x);
      @(posedge clk_sys);
      reg_wr_en <= 1'h0;
      reg_rd_en <= 1'h1;
      reg_addr <= a;
      observe(2'h3, {9'h000, x}, 17'h000FF);
   endtask
   task automatic compare(input logic [16:0] got, input logic [16:0] x, input logic [16:0] m);
      check_count++;
      if ((got & m) !== (x & m)) begin
         err_count++;
         $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got & m, x & m);
      end
   endtask
   // Oldest note against what the block shows half a cycle after the edge
   always @(negedge clk_sys) begin
      if (obs != 2'h0) begin
         compare(obs == 2'h1 ? {a1, a0, ctl, pdn} : obs == 2'h2 ? {16'h0000, addr_match_r} :
                 {9'h000, reg_rdata_r}, q_exp.pop_front(), q_msk.pop_front());
      end
   end
   task automatic wrap_up();
      if (err_count == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Main run takes about 9000 cycles; a hang is cut at 20000
   initial begin
      repeat (20000) @(posedge clk_sys);
      err_count++;
      wrap_up();
   end
   initial begin
      repeat (20) @(posedge clk_sys);
      rst_b <= 1'h1;
      foreach (rst_val[i]) rd(8'(CCP_OFS_SRC_A + i), rst_val[i]);
      wr(8'h08, 8'hA5);
      rd(8'h08, 8'h00);
      rd(8'h0D, 8'h00);
      for (int i = 0; i < 8; i++) begin
         v = xs();
         wr(8'(CCP_OFS_SRC_A + i % 4), v[7:0]);
         rd(8'(CCP_OFS_SRC_A + i % 4), v[7:0]);
      end
      // Every pin mode, pin level, power-down and input type, random sources and codes
      for (int i = 0; i < 1024; i++) begin
         v = xs();
         w = xs();
         r = '{v[7:0], {v[15:13], i[4:0]}, {i[9:8], v[21:16]}, {v[31], i[7], v[29:24]}};
         wr(CCP_OFS_INSRC, r[2]);
         req <= {i[6:5], w[5:0]};
         spread_bypass <= w[6];
         slow <= w[7];
         wr(CCP_OFS_SRC_B, r[3]);
         wr(CCP_OFS_SRC_A, r[0]);
         wr(CCP_OFS_CTRL, r[1]);
         e = exp_stat(r, i[6:5], w[5:0], w[6]);
         ea = {BASE[6:2], e[16], e[15]};
         ca = ea ^ (7'h01 << w[10:8]);
         @(posedge clk_sys);
         reg_wr_en <= 1'h0;
         addr_chk_en <= 1'h1;
         addr_chk_value <= ca;
         observe(2'h2, {16'h0000, ca == ea}, 17'h00001);
         observe(2'h1, e, 17'h1FFFF);
      end
      wrap_up();
   end
endmodule
`default_nettype wire
